//--- video_output_port_formatter.sv
`default_nettype none
module video_output_port_formatter (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pixel_clock,
    input  wire logic        hsync_in,
    input  wire logic [7:0]  red_0,
    input  wire logic [7:0]  green_0,
    input  wire logic [7:0]  blue_0,
    input  wire logic [7:0]  red_1,
    input  wire logic [7:0]  green_1,
    input  wire logic [7:0]  blue_1,
    output logic      [7:0]  red_a,
    output logic      [7:0]  red_b,
    output logic      [7:0]  green_a,
    output logic      [7:0]  green_b,
    output logic      [7:0]  blue_a,
    output logic      [7:0]  blue_b,
    output logic             blue_oe,
    output logic             output_data_clock,
    output logic             hsync_output,
    output logic             input_select,
    output logic      [3:0]  bandwidth_select,
    output logic             external_clock
);
    logic [1:0]  rst_pipe;
    logic        rst_n;
    logic [7:0]  control;
    logic [7:0]  test_a;
    logic [7:0]  test_b;
    logic        hit;
    logic [7:0]  index;
    logic [7:0]  next_rdata;
    logic        wr_go;
    logic        odd_pixel;
    logic        chroma_v;
    logic        hs_prev;
    logic [23:0] held;
    logic [7:0]  fmt_red;
    logic [7:0]  fmt_green;
    logic [7:0]  fmt_blue;
    logic        dual;
    logic        parallel;
    logic        odd_on_a;
    logic        yuv;

    pixel_link_if link ();

    pixel_link_sampler sampler (
        .clock        (clock),
        .rst_n        (rst_n),
        .pixel_clock  (pixel_clock),
        .hsync_in     (hsync_in),
        .red_0        (red_0),
        .green_0      (green_0),
        .blue_0       (blue_0),
        .red_1        (red_1),
        .green_1      (green_1),
        .blue_1       (blue_1),
        .input_select (input_select),
        .link         (link.source)
    );

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    assign dual     = control[video_out_pkg::BIT_DUAL];
    assign parallel = control[video_out_pkg::BIT_PARALLEL];
    assign odd_on_a = control[video_out_pkg::BIT_ODD_SWAP];
    assign yuv      = control[video_out_pkg::BIT_YUV422];

    // Registers sit one per word; the printed offsets are word indices.
    assign index = paddr[9:2];
    assign hit   = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                   (index >= video_out_pkg::IDX_CONTROL) &&
                   (index <= video_out_pkg::IDX_STATUS_B);
    assign wr_go = psel & penable & pready & pwrite & hit;

    always_comb begin
        next_rdata = 8'h00;
        unique case (index)
            video_out_pkg::IDX_CONTROL:  next_rdata = control;
            video_out_pkg::IDX_TEST_A:   next_rdata = test_a;
            video_out_pkg::IDX_TEST_B:   next_rdata = test_b;
            video_out_pkg::IDX_STATUS_A: next_rdata = {4'h0, chroma_v, odd_pixel,
                                                       hsync_output, output_data_clock};
            video_out_pkg::IDX_STATUS_B: next_rdata = green_a;
            default:                     next_rdata = 8'h00;
        endcase
    end

    // The slave answers in the first access cycle; pready comes from a flop.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~pready & ~hit;
            if (psel && !penable && !pready) begin
                prdata <= {24'h0, (hit && !pwrite) ? next_rdata : 8'h00};
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            control <= video_out_pkg::RST_CONTROL;
            test_a  <= video_out_pkg::RST_TEST_A;
            test_b  <= video_out_pkg::RST_TEST_B;
        end else if (wr_go) begin
            if (index == video_out_pkg::IDX_CONTROL) begin
                control <= pwdata[7:0];
            end
            if (index == video_out_pkg::IDX_TEST_A) begin
                test_a <= pwdata[7:0];
            end
            if (index == video_out_pkg::IDX_TEST_B) begin
                test_b <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            input_select     <= 1'b0;
            bandwidth_select <= video_out_pkg::BW_500_MHZ;
            external_clock   <= 1'b0;
        end else begin
            input_select   <= control[video_out_pkg::BIT_IN_SEL];
            external_clock <= control[video_out_pkg::BIT_EXT_CLK];
            unique case ({control[video_out_pkg::BIT_BW_HI], control[video_out_pkg::BIT_BW_LO]})
                2'h3: bandwidth_select <= video_out_pkg::BW_500_MHZ;
                2'h2: bandwidth_select <= video_out_pkg::BW_300_MHZ;
                2'h1: bandwidth_select <= video_out_pkg::BW_150_MHZ;
                2'h0: bandwidth_select <= video_out_pkg::BW_75_MHZ;
            endcase
        end
    end

    // A line starts on an even pixel, so the odd/even split restarts at each sync.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            odd_pixel <= 1'b0;
            chroma_v  <= 1'b0;
            hs_prev   <= 1'b0;
        end else begin
            hs_prev <= link.hsync;
            if (link.hsync && !hs_prev) begin
                odd_pixel <= 1'b0;
                chroma_v  <= 1'b0;
            end else if (link.strobe) begin
                odd_pixel <= ~odd_pixel;
                chroma_v  <= ~chroma_v;
            end
        end
    end

    always_comb begin
        fmt_red   = link.red;
        fmt_green = link.green;
        fmt_blue  = link.blue;
        if (yuv) begin
            fmt_red  = chroma_v ? link.red : link.blue;
            fmt_blue = video_out_pkg::B_IDLE;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            blue_oe <= 1'b1;
        end else begin
            blue_oe <= ~yuv;
        end
    end

    // Each pixel toggles the data clock in both modes; in dual mode the clock
    // follows pixel parity and rises on even pixels, so a period spans a pixel pair.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            output_data_clock <= 1'b0;
        end else if (link.strobe) begin
            output_data_clock <= dual ? ~odd_pixel : ~output_data_clock;
        end
    end

    // Sync follows the data clock edge picked by bit 5, so it lags by up to a pixel.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hsync_output <= 1'b0;
        end else if (link.strobe) begin
            if (odd_on_a == (dual ? ~odd_pixel : ~output_data_clock)) begin
                hsync_output <= link.hsync;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            held    <= 24'h0;
            red_a   <= 8'h00;
            red_b   <= 8'h00;
            green_a <= 8'h00;
            green_b <= 8'h00;
            blue_a  <= 8'h00;
            blue_b  <= 8'h00;
        end else if (link.strobe) begin
            if (!dual) begin
                red_a   <= fmt_red;
                green_a <= fmt_green;
                blue_a  <= fmt_blue;
                red_b   <= video_out_pkg::B_IDLE;
                green_b <= video_out_pkg::B_IDLE;
                blue_b  <= video_out_pkg::B_IDLE;
            end else if (parallel) begin
                if (!odd_pixel) begin
                    held <= {fmt_red, fmt_green, fmt_blue};
                end else if (odd_on_a) begin
                    {red_a, green_a, blue_a} <= {fmt_red, fmt_green, fmt_blue};
                    {red_b, green_b, blue_b} <= held;
                end else begin
                    {red_b, green_b, blue_b} <= {fmt_red, fmt_green, fmt_blue};
                    {red_a, green_a, blue_a} <= held;
                end
            end else begin
                if (odd_pixel != odd_on_a) begin
                    {red_b, green_b, blue_b} <= {fmt_red, fmt_green, fmt_blue};
                end else begin
                    {red_a, green_a, blue_a} <= {fmt_red, fmt_green, fmt_blue};
                end
            end
        end
    end
endmodule : video_output_port_formatter
`default_nettype wire

//--- video_out_pkg.sv
`default_nettype none
package video_out_pkg;
    localparam int unsigned DATA_W       = 8;
    localparam logic [7:0]  IDX_CONTROL  = 8'h15;
    localparam logic [7:0]  IDX_TEST_A   = 8'h16;
    localparam logic [7:0]  IDX_TEST_B   = 8'h17;
    localparam logic [7:0]  IDX_STATUS_A = 8'h18;
    localparam logic [7:0]  IDX_STATUS_B = 8'h19;
    localparam logic [7:0]  RST_CONTROL  = 8'hC6;
    localparam logic [7:0]  RST_TEST_A   = 8'hFF;
    localparam logic [7:0]  RST_TEST_B   = 8'h00;
    localparam int unsigned BIT_DUAL     = 7;
    localparam int unsigned BIT_PARALLEL = 6;
    localparam int unsigned BIT_ODD_SWAP = 5;
    localparam int unsigned BIT_YUV422   = 4;
    localparam int unsigned BIT_IN_SEL   = 3;
    localparam int unsigned BIT_BW_HI    = 2;
    localparam int unsigned BIT_BW_LO    = 1;
    localparam int unsigned BIT_EXT_CLK  = 0;
    localparam logic [3:0]  BW_500_MHZ   = 4'h8;
    localparam logic [3:0]  BW_300_MHZ   = 4'h4;
    localparam logic [3:0]  BW_150_MHZ   = 4'h2;
    localparam logic [3:0]  BW_75_MHZ    = 4'h1;
    localparam logic [7:0]  B_IDLE       = 8'h00;
endpackage : video_out_pkg
`default_nettype wire

//--- pixel_link_if.sv
`default_nettype none
interface pixel_link_if;
    logic       strobe;
    logic       hsync;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    modport source (output strobe, output hsync, output red, output green, output blue);
    modport sink   (input strobe, input hsync, input red, input green, input blue);
endinterface : pixel_link_if
`default_nettype wire

//--- pixel_link_sampler.sv
`default_nettype none
// Brings the pixel clock domain into the system clock domain. Sample data
// must be stable for at least three system clocks around each pixel edge.
module pixel_link_sampler (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       pixel_clock,
    input  wire logic       hsync_in,
    input  wire logic [7:0] red_0,
    input  wire logic [7:0] green_0,
    input  wire logic [7:0] blue_0,
    input  wire logic [7:0] red_1,
    input  wire logic [7:0] green_1,
    input  wire logic [7:0] blue_1,
    input  wire logic       input_select,
    pixel_link_if.source    link
);
    logic [1:0]  clk_sync;
    logic        clk_prev;
    logic [1:0]  hs_sync;
    logic [47:0] data_meta;
    logic [47:0] data_sync;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_sync  <= 2'h0;
            clk_prev  <= 1'b0;
            hs_sync   <= 2'h0;
            data_meta <= 48'h0;
            data_sync <= 48'h0;
        end else begin
            clk_sync  <= {clk_sync[0], pixel_clock};
            clk_prev  <= clk_sync[1];
            hs_sync   <= {hs_sync[0], hsync_in};
            data_meta <= {red_0, green_0, blue_0, red_1, green_1, blue_1};
            data_sync <= data_meta;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            link.strobe <= 1'b0;
            link.hsync  <= 1'b0;
            link.red    <= 8'h00;
            link.green  <= 8'h00;
            link.blue   <= 8'h00;
        end else begin
            link.strobe <= clk_sync[1] & ~clk_prev;
            link.hsync  <= hs_sync[1];
            if (input_select) begin
                link.red   <= data_sync[23:16];
                link.green <= data_sync[15:8];
                link.blue  <= data_sync[7:0];
            end else begin
                link.red   <= data_sync[47:40];
                link.green <= data_sync[39:32];
                link.blue  <= data_sync[31:24];
            end
        end
    end
endmodule : pixel_link_sampler
`default_nettype wire

//--- video_output_port_formatter_assertions.sv
`default_nettype none
module video_output_port_formatter_assertions (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  red_b,
    input wire logic        blue_oe,
    input wire logic        output_data_clock,
    input wire logic        hsync_output,
    input wire logic        input_select,
    input wire logic [3:0]  bandwidth_select
);
    logic [7:0] ctl;
    logic       wr_ctl;
    assign wr_ctl = psel && penable && pready && pwrite && paddr == 12'h054;
    // Shadow of the control register, so the mode-dependent checks follow the chosen mode.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctl <= video_out_pkg::RST_CONTROL;
        end else if (wr_ctl) begin
            ctl <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence beat_s;
        pready ##1 !pready;
    endsequence
    sequence dclk_s;
        $changed(output_data_clock);
    endsequence
    a_apb_one_beat: assert property (setup_s |=> beat_s)
        else $error("pready not one beat");
    a_err_unmapped: assert property (pready && (paddr[1:0] != 2'h0 || paddr < 12'h054
        || paddr > 12'h064) |-> pslverr) else $error("no error on bad address");
    a_input_select: assert property (wr_ctl |-> ##2 input_select == ctl[3])
        else $error("input select wrong");
    a_bandwidth_sel: assert property (wr_ctl |-> ##2 bandwidth_select == (4'h1 << ctl[2:1]))
        else $error("bandwidth wrong");
    a_hsync_edge: assert property (ctl[7] ##0 $changed(hsync_output) |->
        (ctl[5] ? $rose(output_data_clock) : $fell(output_data_clock)))
        else $error("sync on wrong clock edge");
    a_blue_release: assert property (dclk_s |-> blue_oe == !ctl[4])
        else $error("blue enable wrong");
    a_b_idle: assert property (!ctl[7] ##0 dclk_s |-> red_b == video_out_pkg::B_IDLE)
        else $error("port B not idle");
    a_clk_hold: assert property (dclk_s |=> $stable(output_data_clock) [*8])
        else $error("data clock too fast");
endmodule : video_output_port_formatter_assertions
bind video_output_port_formatter video_output_port_formatter_assertions chk (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .red_b(red_b),
    .blue_oe(blue_oe), .output_data_clock(output_data_clock), .hsync_output(hsync_output),
    .input_select(input_select), .bandwidth_select(bandwidth_select)
);
`default_nettype wire

//--- pixel_capture_model.sv
`default_nettype none
module pixel_capture_model (
    input wire logic       clock,
    input wire logic       output_data_clock,
    input wire logic       hsync_output,
    input wire logic       blue_oe,
    input wire logic [7:0] red_a,
    input wire logic [7:0] red_b,
    input wire logic [7:0] green_a
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        last = 1'b0;
    logic [26:0] evq[$];
    // The scaler latches on both data clock edges; the bench sorts them out.
    always @(posedge clock) begin
        if (output_data_clock !== last) begin
            evq.push_back({hsync_output, output_data_clock, blue_oe, red_a, red_b, green_a});
        end
        last <= output_data_clock;
    end
endmodule : pixel_capture_model
`default_nettype wire

//--- video_output_port_formatter_bench.sv
`default_nettype none
module video_output_port_formatter_bench;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin miscompares++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, x); end end
    typedef struct packed {logic [7:0] ctl; logic [3:0] bw;} row_t;
    row_t        rows [7] = '{'{8'h07, 4'h8}, '{8'h0C, 4'h4}, '{8'hC2, 4'h2},
                    '{8'hE0, 4'h1}, '{8'h86, 4'h8}, '{8'hA6, 4'h8}, '{8'h16, 4'h8}};
    int          total_checks = 0;
    int          miscompares = 0;
    logic        clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        e, ph = 1'b0, run = 1'b0, hsync_in = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, q, prdata;
    logic [7:0]  r0 = '0, g0 = '0, b0 = '0, r1 = '0, g1 = '0, b1 = '0;
    logic [7:0]  red_a, red_b, green_a, green_b, blue_a, blue_b;
    logic        pready, pslverr, blue_oe, dclk, hsync_output, input_select, ext_clk;
    logic [3:0]  bandwidth_select;
    wire logic   pixel_clock;
    always #5 clock = ~clock;
    always #62.5 ph = ~ph;
    assign pixel_clock = ph & run;
    video_output_port_formatter dut (
        .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pixel_clock(pixel_clock), .hsync_in(hsync_in), .red_0(r0), .green_0(g0),
        .blue_0(b0), .red_1(r1), .green_1(g1), .blue_1(b1), .red_a(red_a), .red_b(red_b),
        .green_a(green_a), .green_b(green_b), .blue_a(blue_a), .blue_b(blue_b),
        .blue_oe(blue_oe), .output_data_clock(dclk), .hsync_output(hsync_output),
        .input_select(input_select), .bandwidth_select(bandwidth_select),
        .external_clock(ext_clk));
    pixel_capture_model cap (.clock(clock), .output_data_clock(dclk),
        .hsync_output(hsync_output), .blue_oe(blue_oe),
        .red_a(red_a), .red_b(red_b), .green_a(green_a));
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            end_of_test();
        end
    endtask : apb
    // The pixel clock stands still outside a line; sync spans pixels 0 and 1, which
    // prime parity and the sync output, and in dual mode load port data that is still read at pixel 2.
    task automatic line();
        logic [7:0] p;
        for (int k = 0; k < 10; k++) begin
            p = 8'(k);
            @(negedge ph);
            @(posedge clock);
            {r0, g0, b0} <= {p + 8'h10, p + 8'h20, p + 8'h40};
            {r1, g1, b1} <= {p + 8'h90, p + 8'hA0, p + 8'hC0};
            hsync_in <= (k < 2);
            run <= 1'b1;
            if (k == 2) cap.evq.delete();
        end
        @(negedge ph);
        @(posedge clock);
        run <= 1'b0;
        repeat (8) @(posedge clock);
    endtask : line
    task automatic check_line(input logic [7:0] c);
        logic [26:0] ev;
        logic [7:0]  off, p, o, x, s;
        `CHK(cap.evq.size(), 8)
        off = c[3] ? 8'h90 : 8'h10;
        for (int j = 0; j < 8; j++) begin
            ev = cap.evq[j];
            p = 8'(j + 2);
            `CHK(ev[26], p == 8'h02 && !c[5])
            if (!c[7]) begin
                x = (c[4] && !p[0]) ? p + (c[3] ? 8'hC0 : 8'h40) : p + off;
                `CHK(ev[23:16], x)
                `CHK(ev[15:8], video_out_pkg::B_IDLE)
                `CHK(ev[7:0], p + (c[3] ? 8'hA0 : 8'h20))
                `CHK(ev[24], !c[4])
            end else begin
                o = p[0] ? p + off : p + off - 8'h01;
                x = p[0] ? p + off - 8'h01 : (c[6] ? p + off - 8'h02 : p + off);
                `CHK(ev[25], !p[0])
                `CHK(ev[23:16], c[5] ? o : x)
                `CHK(ev[15:8], c[5] ? x : o)
            end
        end
        s = c[3] ? 8'h80 : 8'h00;
        o = c[5] ? 8'h09 : 8'h08;
        // Pixel 9 ends the line, so its outputs stand while these are read.
        if (!c[7]) begin
            `CHK({green_b, blue_b}, {2{video_out_pkg::B_IDLE}})
            `CHK(blue_a, c[4] ? video_out_pkg::B_IDLE : 8'h49 + s)
        end else begin
            `CHK(blue_a, o + 8'h40 + s)
            `CHK(blue_b, (o ^ 8'h01) + 8'h40 + s)
            `CHK(green_b, (o ^ 8'h01) + 8'h20 + s)
        end
    endtask : check_line
    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        foreach (rows[i]) begin
            apb(1'b1, 12'h054, {24'h0, rows[i].ctl});
            // The copies follow the control register one edge after the write lands.
            repeat (2) @(posedge clock);
            `CHK(input_select, rows[i].ctl[3])
            `CHK(bandwidth_select, rows[i].bw)
            `CHK(ext_clk, rows[i].ctl[0])
            line();
            check_line(rows[i].ctl);
        end
        apb(1'b0, 12'h064, 32'h0);
        `CHK(q, 32'h00000029)
        apb(1'b1, 12'h05C, 32'h0000005A);
        apb(1'b0, 12'h05C, 32'h0);
        `CHK(q[7:0], 8'h5A)
        apb(1'b1, 12'h060, 32'h000000FF);
        `CHK(e, 1'b0)
        apb(1'b0, 12'h100, 32'h0);
        `CHK({e, q}, {1'b1, 32'h0})
        apb(1'b1, 12'h055, 32'h0);
        `CHK(e, 1'b1)
        nrst <= 1'b0;
        @(posedge clock);
        `CHK({blue_oe, bandwidth_select}, 5'h18)
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        apb(1'b0, 12'h054, 32'h0);
        `CHK(q[7:0], video_out_pkg::RST_CONTROL)
        apb(1'b0, 12'h058, 32'h0);
        `CHK(q[7:0], video_out_pkg::RST_TEST_A)
        apb(1'b0, 12'h05C, 32'h0);
        `CHK(q[7:0], video_out_pkg::RST_TEST_B)
        end_of_test();
    end
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
endmodule : video_output_port_formatter_bench
`default_nettype wire
